// >>> common/ppmbw_cfg.svh
`ifndef PPMBW_CFG_SVH
`define PPMBW_CFG_SVH

// Command codes
`define PPMBW_CMD_HIGH_POWER  8'h40
`define PPMBW_CMD_FW_REV      8'h41
`define PPMBW_CMD_WATCHDOG    8'h42

// Field positions
`define PPMBW_HP_LSB          4
`define PPMBW_ONCHK_BIT       0
`define PPMBW_WDKEY_LSB       1
`define PPMBW_WDFLAG_BIT      0

// Reset values and codes
`define PPMBW_HP_RESET        4'h0
`define PPMBW_ONCHK_RESET     1'b0
`define PPMBW_WDKEY_RESET     4'hB
`define PPMBW_WDKEY_MASKED    4'hB
`define PPMBW_POLICE_HP       4'h0
`define PPMBW_POLICE_NORMAL   4'hF
`define PPMBW_POLICE_CLASS4   4'h8
`define PPMBW_FW_REV_DEFAULT  8'h01

// Timing
`define PPMBW_CLK_MHZ         200
`define PPMBW_WD_TIMEOUT_MS   2000
`define PPMBW_WD_TIMEOUT_CYCLES (`PPMBW_WD_TIMEOUT_MS * `PPMBW_CLK_MHZ * 1000)

`endif

// >>> common/ppmbw_pkg.sv
package ppmbw_pkg;

   typedef enum logic [1:0] {
      PON_IDLE,
      PON_WAIT_DET,
      PON_RETRY_DET,
      PON_ON
   } ppmbw_pon_state_e;

   typedef logic [3:0] ppmbw_police_t;

endpackage : ppmbw_pkg

// >>> design/ppmbw_watchdog.sv
`timescale 1ns/100ps
`include "ppmbw_cfg.svh"

module ppmbw_watchdog #(
   parameter int TIMEOUT_CYCLES = `PPMBW_WD_TIMEOUT_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic rstN,
   input  wire logic sclPin,
   output logic      expirePulse,
   output logic      sclEdge
);

   logic        sclMeta;
   logic        sclSync;
   logic        sclLast;
   logic [31:0] count;
   logic        fired;

   // Pin crosses in through two flops
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         sclMeta <= 1'b1;
         sclSync <= 1'b1;
         sclLast <= 1'b1;
      end else begin
         sclMeta <= sclPin;
         sclSync <= sclMeta;
         sclLast <= sclSync;
      end
   end

   assign sclEdge = sclSync ^ sclLast; // (R10)

   // Counter holds at the end so expiry fires once per idle spell
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         count       <= 32'h00000000;
         fired       <= 1'b0;
         expirePulse <= 1'b0;
      end else begin
         expirePulse <= 1'b0;
         if (sclEdge) begin
            count <= 32'h00000000; // (R10)
            fired <= 1'b0;
         end else if (count < 32'(TIMEOUT_CYCLES - 1)) begin
            count <= count + 32'h00000001;
         end else if (!fired) begin
            fired       <= 1'b1;
            expirePulse <= 1'b1; // (R11)
         end
      end
   end

   a_wd_restart_edge: assert property (@(posedge core_clk) disable iff (!rstN) // (R10)
      sclEdge |=> (count == 32'h00000000) && !expirePulse)
      else $error("watchdog count not restarted by clock edge");

endmodule : ppmbw_watchdog

// >>> design/ppmbw_top.sv
`timescale 1ns/100ps
`include "ppmbw_cfg.svh"

// Function
// (R01) High-power bit raises a port's limit and short thresholds about 2.5x.
// (R02) Fault timer runs when current exceeds limit, or cut threshold when enabled.
// (R03) Inrush profile at turn-on is the same whatever the high-power bit.
// (R04) Setting high-power bit loads police code 0x0; clearing loads 0xF.
// (R05) High-power clear uses nominal 60 ms limit time; set uses programmed time.
// (R06) Pushbutton turn-on with class 4 sets high-power bit and police 08h.
// (R07) Timing check on: power after detection only if turn-on time met.
// (R08) Time missed: redetect and classify, power only if valid, no more tries.
// (R09) Timing check off: power-on request powers the port at once.
// (R10) Watchdog count restarts on every clock-line edge.
// (R11) No clock edge for 2 s expires watchdog and sets its flag.
// (R12) Disable key 1011b, the reset value, masks the watchdog.
// (R13) Expired flag reports even when masked; host clears by writing zero.
// (R14) Unmasked expiry turns off all eight ports.
// (R15) Watchdog shutdown clears the ports' event, status and enable bits.
// (R16) Watchdog shutdown sets power change events and updates power status.
// (R17) Read-only firmware revision byte at command 41h.
// (R18) Watchdog control and status byte at command 42h.
// (R19) High-power and timing check bits byte at command 40h.
// (R20) After expiry monitor registers freeze until the flag is cleared.
// (R21) Expired flag stays set until the host writes zero.
module ppmbw_top #(
   parameter int         PORTS          = 8,
   parameter int         HP_PORTS       = 4,
   parameter int         WD_TIMEOUT     = `PPMBW_WD_TIMEOUT_CYCLES,
   parameter logic [7:0] FW_REV         = `PPMBW_FW_REV_DEFAULT // Arbitrary value
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst_b,
   input  wire logic                  sclPin,
   input  wire logic [7:0]            regCmd,
   input  wire logic                  regWrEn,
   input  wire logic [7:0]            regWrData,
   output logic      [7:0]            regRdData,
   input  wire logic [PORTS-1:0]      powerOnReq,
   input  wire logic [PORTS-1:0]      semiautoMode,
   input  wire logic [PORTS-1:0]      detectEnable,
   input  wire logic [PORTS-1:0]      classEnable,
   input  wire logic [PORTS-1:0]      detectDone,
   input  wire logic [PORTS-1:0]      detectValid,
   input  wire logic [PORTS-1:0]      classValid,
   input  wire logic [PORTS-1:0]      onTimeMet,
   input  wire logic [PORTS-1:0]      pushbuttonOn,
   input  wire logic [PORTS-1:0]      class4Found,
   input  wire logic [PORTS-1:0]      inrushDone,
   input  wire logic [PORTS-1:0]      portOffReq,
   input  wire logic [PORTS-1:0]      powerGood,
   input  wire logic [PORTS-1:0]      aboveLimit,
   input  wire logic [PORTS-1:0]      aboveCut,
   input  wire logic [PORTS-1:0]      cutEnable,
   output logic      [PORTS-1:0]      portPowerEnable,
   output logic      [PORTS-1:0]      restartDetect,
   output logic      [PORTS-1:0]      faultTimerRun,
   output logic      [HP_PORTS-1:0]   limitScaleHigh,
   output logic      [HP_PORTS-1:0]   limitTimeProg,
   output logic      [HP_PORTS-1:0]   inrushProfileHigh,
   output logic      [HP_PORTS-1:0]   policeLoad,
   output logic      [4*HP_PORTS-1:0] policeCode,
   output logic                       wdShutdown,
   output logic      [PORTS-1:0]      clearPortEvents,
   output logic      [PORTS-1:0]      powerEnableChangeSet,
   output logic      [PORTS-1:0]      powerGoodChangeSet,
   output logic      [PORTS-1:0]      powerGoodStatus,
   output logic                       monitorFreeze,
   output logic                       watchdogExpiredFlag
);

   logic                rstMeta;
   logic                rstN;
   logic [HP_PORTS-1:0] portHighPowerBits;
   logic                turnOnTimingCheck;
   logic [3:0]          watchdogDisableKey;
   logic                wdMasked;
   logic                expirePulse;
   logic                wrHighPower;
   logic                wrWatchdog;
   logic                wdFlagClear;
   logic [PORTS-1:0]    pbLatched;
   logic [PORTS-1:0]    class4Apply;

   // Reset released through two flops
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta <= 1'b0;
         rstN    <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN    <= rstMeta;
      end
   end

   ppmbw_watchdog #(
      .TIMEOUT_CYCLES (WD_TIMEOUT)
   ) u_watchdog (
      .core_clk    (core_clk),
      .rstN        (rstN),
      .sclPin      (sclPin),
      .expirePulse (expirePulse),
      .sclEdge     ()
   );

   assign wrHighPower = regWrEn && (regCmd == `PPMBW_CMD_HIGH_POWER); // (R19)
   assign wrWatchdog  = regWrEn && (regCmd == `PPMBW_CMD_WATCHDOG); // (R18)
   assign wdFlagClear = wrWatchdog && !regWrData[`PPMBW_WDFLAG_BIT]; // (R13)
   assign wdMasked    = (watchdogDisableKey == `PPMBW_WDKEY_MASKED); // (R12)
   assign wdShutdown  = expirePulse && !wdMasked; // (R14)

   // Watchdog control: key and sticky expiry flag, set beats clear
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         watchdogDisableKey  <= `PPMBW_WDKEY_RESET; // (R12)
         watchdogExpiredFlag <= 1'b0;
      end else begin
         if (wrWatchdog) begin
            watchdogDisableKey <= regWrData[`PPMBW_WDKEY_LSB +: 4];
         end
         if (expirePulse) begin
            watchdogExpiredFlag <= 1'b1; // (R11) (R13)
         end else if (wdFlagClear) begin
            watchdogExpiredFlag <= 1'b0; // (R21)
         end
      end
   end

   // Freeze follows the flag so monitors restart only on host clear
   assign monitorFreeze = watchdogExpiredFlag; // (R20)

   // Timing check bit
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         turnOnTimingCheck <= `PPMBW_ONCHK_RESET;
      end else if (wrHighPower) begin
         turnOnTimingCheck <= regWrData[`PPMBW_ONCHK_BIT];
      end
   end

   // Registered read data, one cycle after the command
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         regRdData <= 8'h00;
      end else begin
         case (regCmd)
            `PPMBW_CMD_HIGH_POWER: regRdData <= {portHighPowerBits, 3'h0, turnOnTimingCheck}; // (R19)
            `PPMBW_CMD_FW_REV:     regRdData <= FW_REV; // (R17)
            `PPMBW_CMD_WATCHDOG:   regRdData <= {3'h0, watchdogDisableKey, watchdogExpiredFlag}; // (R18)
            default:               regRdData <= 8'h00;
         endcase
      end
   end

   // Shutdown side effects toward event and status registers
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         clearPortEvents      <= '0;
         powerEnableChangeSet <= '0;
         powerGoodChangeSet   <= '0;
         powerGoodStatus      <= '0;
      end else begin
         clearPortEvents      <= wdShutdown ? {PORTS{1'b1}} : '0; // (R15)
         powerEnableChangeSet <= wdShutdown ? portPowerEnable : '0; // (R16)
         powerGoodChangeSet   <= wdShutdown ? (powerGood & portPowerEnable) : '0; // (R16)
         powerGoodStatus      <= wdShutdown ? '0 : (powerGood & portPowerEnable); // (R16)
      end
   end

   // Fault timer start condition
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         faultTimerRun <= '0;
      end else begin
         faultTimerRun <= aboveLimit | (aboveCut & cutEnable); // (R02)
      end
   end

   // High-power bits scale limits and pick the programmed limit time
   assign limitScaleHigh    = portHighPowerBits; // (R01)
   assign limitTimeProg     = portHighPowerBits; // (R05)
   // Inrush stays on the standard profile; no high-power option exists
   assign inrushProfileHigh = '0; // (R03)

   genvar g;
   generate
      for (g = 0; g < PORTS; g++) begin : g_port
         ppmbw_pkg::ppmbw_pon_state_e ponState;
         logic                        detectOk;

         assign detectOk = detectValid[g] && (classValid[g] || !classEnable[g]);

         // Power-on sequencing per port
         always_ff @(posedge core_clk or negedge rstN) begin
            if (!rstN) begin
               ponState         <= ppmbw_pkg::PON_IDLE;
               restartDetect[g] <= 1'b0;
            end else begin
               restartDetect[g] <= 1'b0;
               if (wdShutdown || portOffReq[g]) begin
                  ponState <= ppmbw_pkg::PON_IDLE; // (R14)
               end else begin
                  case (ponState)
                     ppmbw_pkg::PON_IDLE: begin
                        if (powerOnReq[g]) begin
                           if (turnOnTimingCheck && detectEnable[g] && semiautoMode[g]) begin
                              ponState <= ppmbw_pkg::PON_WAIT_DET; // (R07)
                           end else begin
                              ponState <= ppmbw_pkg::PON_ON; // (R09)
                           end
                        end
                     end
                     ppmbw_pkg::PON_WAIT_DET: begin
                        if (detectDone[g] && detectOk) begin
                           if (onTimeMet[g]) begin
                              ponState <= ppmbw_pkg::PON_ON; // (R07)
                           end else begin
                              ponState         <= ppmbw_pkg::PON_RETRY_DET; // (R08)
                              restartDetect[g] <= 1'b1;
                           end
                        end
                     end
                     ppmbw_pkg::PON_RETRY_DET: begin
                        if (detectDone[g]) begin
                           // Single retry; a new request is needed after a miss
                           ponState <= detectValid[g] ? ppmbw_pkg::PON_ON : ppmbw_pkg::PON_IDLE; // (R08)
                        end
                     end
                     ppmbw_pkg::PON_ON: begin
                        ponState <= ppmbw_pkg::PON_ON;
                     end
                     default: ponState <= ppmbw_pkg::PON_IDLE;
                  endcase
               end
            end
         end

         assign portPowerEnable[g] = (ponState == ppmbw_pkg::PON_ON);

         // Remember pushbutton turn-on until inrush completes
         always_ff @(posedge core_clk or negedge rstN) begin
            if (!rstN) begin
               pbLatched[g] <= 1'b0;
            end else if (wdShutdown || portOffReq[g] || inrushDone[g]) begin
               pbLatched[g] <= 1'b0;
            end else if (pushbuttonOn[g]) begin
               pbLatched[g] <= 1'b1;
            end
         end

         assign class4Apply[g] = pbLatched[g] && inrushDone[g] && class4Found[g]; // (R06)
      end

      for (g = 0; g < HP_PORTS; g++) begin : g_hp
         // High-power bit and its police reload
         always_ff @(posedge core_clk or negedge rstN) begin
            if (!rstN) begin
               portHighPowerBits[g]    <= 1'b0;
               policeLoad[g]           <= 1'b0;
               policeCode[4*g +: 4]    <= `PPMBW_POLICE_NORMAL;
            end else begin
               policeLoad[g] <= 1'b0;
               if (class4Apply[g]) begin
                  portHighPowerBits[g] <= 1'b1; // (R06)
                  policeLoad[g]        <= 1'b1;
                  policeCode[4*g +: 4] <= `PPMBW_POLICE_CLASS4; // (R06)
               end else if (wrHighPower &&
                            (regWrData[`PPMBW_HP_LSB + g] != portHighPowerBits[g])) begin
                  portHighPowerBits[g] <= regWrData[`PPMBW_HP_LSB + g]; // (R01)
                  policeLoad[g]        <= 1'b1;
                  policeCode[4*g +: 4] <= regWrData[`PPMBW_HP_LSB + g] ?
                                          `PPMBW_POLICE_HP : `PPMBW_POLICE_NORMAL; // (R04)
               end
            end
         end

         a_hp_police_zero: assert property (@(posedge core_clk) disable iff (!rstN) // (R04)
            wrHighPower && regWrData[`PPMBW_HP_LSB + g] && !portHighPowerBits[g] && !class4Apply[g]
            |=> policeLoad[g] && (policeCode[4*g +: 4] == 4'h0) && portHighPowerBits[g])
            else $error("police code not zeroed on high-power set");
      end
   endgenerate

   sequence s_expire_unmasked;
      expirePulse && !wdMasked;
   endsequence

   sequence s_ports_dark;
      (portPowerEnable == '0) && (clearPortEvents == {PORTS{1'b1}});
   endsequence

   a_wd_ports_off: assert property (@(posedge core_clk) disable iff (!rstN) // (R14) (R15)
      s_expire_unmasked |=> s_ports_dark)
      else $error("ports not shut after watchdog expiry");

   a_wd_masked_keep: assert property (@(posedge core_clk) disable iff (!rstN) // (R12)
      expirePulse && wdMasked && !wdFlagClear |=> watchdogExpiredFlag && (clearPortEvents == '0))
      else $error("masked watchdog acted on ports");

   a_wd_flag_hold: assert property (@(posedge core_clk) disable iff (!rstN) // (R21)
      watchdogExpiredFlag && !wdFlagClear |=> watchdogExpiredFlag)
      else $error("expired flag dropped without host clear");

   a_wd_flag_clear: assert property (@(posedge core_clk) disable iff (!rstN) // (R13)
      wdFlagClear && !expirePulse |=> !watchdogExpiredFlag && !monitorFreeze)
      else $error("expired flag not cleared by write of zero");

   a_wd_pec_set: assert property (@(posedge core_clk) disable iff (!rstN) // (R16)
      wdShutdown |=> powerEnableChangeSet == $past(portPowerEnable))
      else $error("power enable change events wrong after shutdown");

   a_fault_timer: assert property (@(posedge core_clk) disable iff (!rstN) // (R02)
      aboveCut[0] && cutEnable[0] |=> faultTimerRun[0])
      else $error("fault timer not started on cut threshold");

   a_pwr_immediate: assert property (@(posedge core_clk) disable iff (!rstN) // (R09)
      powerOnReq[0] && !turnOnTimingCheck && !portOffReq[0] && !wdShutdown
      && (g_port[0].ponState == ppmbw_pkg::PON_IDLE) |=> portPowerEnable[0])
      else $error("power-on request not honoured at once");

   sequence s_ontime_miss;
      (g_port[0].ponState == ppmbw_pkg::PON_WAIT_DET) && detectDone[0] && g_port[0].detectOk
      && !onTimeMet[0] && !portOffReq[0] && !wdShutdown;
   endsequence

   a_ontime_retry: assert property (@(posedge core_clk) disable iff (!rstN) // (R08)
      s_ontime_miss |=> restartDetect[0] && !portPowerEnable[0])
      else $error("missed turn-on time did not restart detection");

   a_class4_load: assert property (@(posedge core_clk) disable iff (!rstN) // (R06)
      class4Apply[0] |=> portHighPowerBits[0] && policeLoad[0] && (policeCode[3:0] == 4'h8))
      else $error("class 4 pushbutton did not load police code");

endmodule : ppmbw_top

// >>> bench/ppmbw_host_model.sv
`timescale 1ns/100ps
module ppmbw_host_model (
   input  wire logic       core_clk,
   input  wire logic       sclRun,
   output logic            sclPin,
   output logic [7:0]      regCmd,
   output logic            regWrEn,
   output logic [7:0]      regWrData,
   input  wire logic [7:0] regRdData
);
   initial begin
      sclPin = 1'b1;
      regCmd = 8'h00;
      regWrEn = 1'b0;
      regWrData = 8'h00;
   end

   // Clock line parks high on its pull-up between frames
   always begin
      #32;
      sclPin = sclRun ? ~sclPin : 1'b1;
   end

   // Host clears the expired flag only through a write of zero
   task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
      @(negedge core_clk);
      regCmd = cmd;
      regWrData = data;
      regWrEn = 1'b1;
      @(negedge core_clk);
      regWrEn = 1'b0;
      regWrData = ~data;
   endtask : wr

   task automatic rd(input logic [7:0] cmd, output logic [7:0] data);
      @(negedge core_clk);
      regCmd = cmd;
      @(negedge core_clk);
      data = regRdData;
   endtask : rd
endmodule : ppmbw_host_model

// >>> bench/test_ppmbw_top.sv
`timescale 1ns/100ps
module test_ppmbw_top;
   localparam int         WDT = 200;
   localparam logic [7:0] FW  = 8'h5A; // Arbitrary value

   logic        core_clk = 1'b0, rst_b = 1'b0, sclRun = 1'b1;
   logic        sclPin, regWrEn, wdShutdown, monitorFreeze, watchdogExpiredFlag;
   logic [7:0]  regCmd, regWrData, regRdData, rdVal;
   logic [7:0]  powerOnReq = 8'h00, semiautoMode = 8'h00, detectEnable = 8'h00;
   logic [7:0]  classEnable = 8'h00, detectDone = 8'h00, detectValid = 8'h00;
   logic [7:0]  classValid = 8'h00, onTimeMet = 8'h00, pushbuttonOn = 8'h00;
   logic [7:0]  class4Found = 8'h00, inrushDone = 8'h00, portOffReq = 8'h00;
   logic [7:0]  powerGood = 8'h00, aboveLimit = 8'h00, aboveCut = 8'h00, cutEnable = 8'h00;
   logic [7:0]  portPowerEnable, restartDetect, faultTimerRun, clearPortEvents;
   logic [7:0]  powerEnableChangeSet, powerGoodChangeSet, powerGoodStatus;
   logic [3:0]  limitScaleHigh, limitTimeProg, inrushProfileHigh, policeLoad;
   logic [15:0] policeCode;
   int          checks = 0, miscompares = 0;

   always #2.5 core_clk = ~core_clk;

   ppmbw_host_model host (.core_clk, .sclRun, .sclPin, .regCmd, .regWrEn, .regWrData, .regRdData);

   ppmbw_top #(.WD_TIMEOUT(WDT), .FW_REV(FW)) uut (
      .core_clk, .rst_b, .sclPin, .regCmd, .regWrEn, .regWrData, .regRdData,
      .powerOnReq, .semiautoMode, .detectEnable, .classEnable, .detectDone,
      .detectValid, .classValid, .onTimeMet, .pushbuttonOn, .class4Found,
      .inrushDone, .portOffReq, .powerGood, .aboveLimit, .aboveCut, .cutEnable,
      .portPowerEnable, .restartDetect, .faultTimerRun, .limitScaleHigh,
      .limitTimeProg, .inrushProfileHigh, .policeLoad, .policeCode, .wdShutdown,
      .clearPortEvents, .powerEnableChangeSet, .powerGoodChangeSet,
      .powerGoodStatus, .monitorFreeze, .watchdogExpiredFlag
   );

   task automatic final_report();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report

   task automatic cmp_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_reg

   task automatic cmp_port(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_port

   task automatic rdc(input logic [7:0] cmd, input logic [7:0] exp, input string what);
      host.rd(cmd, rdVal);
      cmp_reg(what, exp, rdVal);
   endtask : rdc

   task automatic step(input int n);
      repeat (n) @(negedge core_clk);
   endtask : step

   task automatic det(input logic [7:0] done, input logic [7:0] ok, input logic [7:0] met);
      @(negedge core_clk);
      detectDone = done;
      detectValid = ok;
      onTimeMet = met;
      @(negedge core_clk);
      detectDone = 8'h00;
   endtask : det

   task automatic pon(input logic [7:0] ports);
      @(negedge core_clk);
      powerOnReq = ports;
      @(negedge core_clk);
      powerOnReq = 8'h00;
   endtask : pon

   // Stops on the shutdown pulse or, when masked, on the expired flag, so the cycle after it can be inspected
   task automatic wait_wd();
      int n;
      n = 0;
      while (wdShutdown !== 1'b1 && watchdogExpiredFlag !== 1'b1) begin
         step(1);
         n++;
         if (n > 2 * WDT) begin
            miscompares++;
            $display("CHECK FAILED watchdog wait expected expiry seen none");
            final_report();
         end
      end
   endtask : wait_wd

   initial begin
      step(16);
      rst_b = 1'b1;
      step(4);
      cmp_port("police rst", 16'hFFFF, policeCode);
      rdc(8'h40, 8'h00, "hp rst");
      rdc(8'h42, 8'h16, "wd rst");
      rdc(8'h41, FW, "fw rst");
      rdc(8'h55, 8'h00, "unmapped");
      host.wr(8'h41, 8'hA5);
      rdc(8'h41, FW, "fw ro");
      host.wr(8'h40, 8'hF1);
      cmp_port("police ld", 16'h000F, {12'h000, policeLoad});
      cmp_port("scale hp", 16'h00FF, {8'h00, limitScaleHigh, limitTimeProg});
      cmp_port("police hp", 16'h0000, policeCode);
      cmp_port("inrush", 16'h0000, {12'h000, inrushProfileHigh});
      rdc(8'h40, 8'hF1, "hp rb");
      host.wr(8'h40, 8'h01);
      cmp_port("police nrm", 16'hFFFF, policeCode);
      cmp_port("scale nrm", 16'h0000, {8'h00, limitScaleHigh, limitTimeProg});
      semiautoMode = 8'h0F;
      detectEnable = 8'h0F;
      pon(8'h0E);
      step(2);
      cmp_port("pwr wait", 16'h0000, {8'h00, portPowerEnable});
      det(8'h02, 8'h02, 8'h02);
      cmp_port("pwr met", 16'h0002, {8'h00, portPowerEnable});
      det(8'h0C, 8'h0C, 8'h00);
      cmp_port("restart", 16'h000C, {8'h00, restartDetect});
      cmp_port("pwr miss", 16'h0002, {8'h00, portPowerEnable});
      det(8'h0C, 8'h04, 8'h00);
      cmp_port("pwr retry", 16'h0006, {8'h00, portPowerEnable});
      det(8'h08, 8'h08, 8'h08);
      cmp_port("no retry", 16'h0006, {8'h00, portPowerEnable});
      host.wr(8'h40, 8'h00);
      detectValid = 8'h00;
      pon(8'h01);
      cmp_port("pwr now", 16'h0007, {8'h00, portPowerEnable});
      aboveLimit = 8'h01;
      aboveCut = 8'h06;
      cutEnable = 8'h04;
      step(2);
      cmp_port("fault", 16'h0005, {8'h00, faultTimerRun});
      class4Found = 8'h01;
      @(negedge core_clk);
      pushbuttonOn = 8'h01;
      @(negedge core_clk);
      pushbuttonOn = 8'h00;
      inrushDone = 8'h01;
      @(negedge core_clk);
      inrushDone = 8'h00;
      cmp_port("c4 police", 16'hFFF8, policeCode);
      cmp_port("c4 load", 16'h0001, {12'h000, policeLoad});
      rdc(8'h40, 8'h10, "c4 hp");
      host.wr(8'h40, 8'h00);
      cmp_port("police clr", 16'hFFFF, policeCode);
      powerGood = 8'hFF;
      step(2);
      cmp_port("pg stat", 16'h0007, {8'h00, powerGoodStatus});
      sclRun = 1'b0;
      step(150);
      cmp_port("wd early", 16'h0000, {15'h0000, watchdogExpiredFlag});
      wait_wd();
      step(1);
      cmp_port("flag masked", 16'h0001, {15'h0000, watchdogExpiredFlag});
      cmp_port("pwr masked", 16'h0007, {8'h00, portPowerEnable});
      cmp_port("freeze", 16'h0001, {15'h0000, monitorFreeze});
      rdc(8'h42, 8'h17, "wd flag rd");
      sclRun = 1'b1;
      step(40);
      cmp_port("flag held", 16'h0001, {15'h0000, watchdogExpiredFlag});
      host.wr(8'h42, 8'h00);
      cmp_port("flag clr", 16'h0000, {15'h0000, watchdogExpiredFlag});
      cmp_port("unfreeze", 16'h0000, {15'h0000, monitorFreeze});
      step(3 * WDT);
      cmp_port("wd kept", 16'h0000, {15'h0000, watchdogExpiredFlag});
      sclRun = 1'b0;
      wait_wd();
      cmp_port("shutdown", 16'h0001, {15'h0000, wdShutdown});
      step(1);
      cmp_port("pwr off", 16'h0000, {8'h00, portPowerEnable});
      cmp_port("clear ev", 16'h00FF, {8'h00, clearPortEvents});
      cmp_port("pe chg", 16'h0007, {8'h00, powerEnableChangeSet});
      cmp_port("pg chg", 16'h0007, {8'h00, powerGoodChangeSet});
      cmp_port("pg off", 16'h0000, {8'h00, powerGoodStatus});
      cmp_port("flag set", 16'h0001, {15'h0000, watchdogExpiredFlag});
      final_report();
   end
endmodule : test_ppmbw_top
